// ### dpsc_pkg.sv
`default_nettype none
package dpsc_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_SAVE_CH1 = 8'h20;
	localparam logic [7:0] OP_STORE_A = 8'h32;
	localparam logic [7:0] OP_STORE_B = 8'h33;
	localparam logic [7:0] OP_READ_C = 8'h94;
	localparam logic [7:0] OP_LOAD_CH1 = 8'hB0;
	localparam logic [7:0] OP_LOAD_CH2 = 8'hB1;
	localparam logic [7:0] OP_SHL_CH2 = 8'hC1;
	localparam logic [7:0] OP_INC_CH1 = 8'hE0;
	localparam logic [7:0] WIPER_MAX = 8'hFF;
	localparam logic [7:0] NV_RESET = 8'h80;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage
`default_nettype wire

// ### dpsc_shift.sv
`default_nettype none
// Serial frame receiver/transmitter on sampled link pins
module dpsc_shift (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic [15:0] tx_word_i,
	output logic miso_o,
	output logic frame_done_o,
	output logic [15:0] rx_word_o
);
	logic [2:0] sclk_s;
	logic [1:0] cs_s;
	logic [1:0] mosi_s;
	logic [15:0] rx_sh;
	logic [15:0] tx_sh;
	logic [4:0] cnt;

	// Two-stage synchronisers plus edge history
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_s <= 3'h0;
			cs_s <= 2'h3;
			mosi_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk_i};
			cs_s <= {cs_s[0], cs_n_i};
			mosi_s <= {mosi_s[0], mosi_i};
		end
	end

	// Sample on rising edge, shift out on falling edge, MSB first
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_sh <= 16'h0000;
			tx_sh <= 16'h0000;
			cnt <= 5'h00;
			frame_done_o <= 1'b0;
			rx_word_o <= 16'h0000;
			miso_o <= 1'b0;
		end else begin
			frame_done_o <= 1'b0;
			if (cs_s[1]) begin
				cnt <= 5'h00;
				tx_sh <= tx_word_i;
				miso_o <= tx_word_i[15];
			end else if (sclk_s[1] && !sclk_s[2]) begin
				rx_sh <= {rx_sh[14:0], mosi_s[1]};
				cnt <= cnt + 5'h01;
				if (cnt == 5'(dpsc_pkg::FRAME_BITS - 1)) begin
					frame_done_o <= 1'b1;
					rx_word_o <= {rx_sh[14:0], mosi_s[1]};
				end
			end else if (!sclk_s[1] && sclk_s[2]) begin
				tx_sh <= {tx_sh[14:0], 1'b0};
				miso_o <= tx_sh[14];
			end
		end
	end
endmodule
`default_nettype wire

// ### dpsc_core.sv
`default_nettype none
module dpsc_core (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic serial_in_line_i,
	input wire logic wp_n_i,
	input wire logic preset_strobe_n_i,
	output logic serial_out_line_o,
	output logic [7:0] wiper_setting_ch1_o,
	output logic [7:0] wiper_setting_ch2_o,
	output logic [7:0] nv_wiper_copy_ch1_o,
	output logic [7:0] spare_nv_slot_a_o,
	output logic [7:0] spare_nv_slot_b_o,
	output logic idle_o
);
	typedef enum logic [1:0] {
		DPSC_IDLE = 2'b01,
		DPSC_BUSY = 2'b10
	} dpsc_state_e;

	logic miso;
	logic frame_done;
	logic [15:0] rx_word;
	logic [15:0] tx_word;
	logic [7:0] op;
	logic [7:0] data;
	logic [7:0] nv_ch2;
	logic [7:0] slot_c;
	logic [1:0] wp_s;
	logic [1:0] preset_s;
	logic preset_d;
	logic preset_fire;
	logic wp_ok;
	dpsc_state_e state;

	// Double with saturation
	function automatic logic [7:0] dpsc_dbl(input logic [7:0] v);
		dpsc_dbl = v[7] ? dpsc_pkg::WIPER_MAX : {v[6:0], 1'b0};
	endfunction

	dpsc_shift u_shift (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.mosi_i(serial_in_line_i),
		.tx_word_i(tx_word),
		.miso_o(miso),
		.frame_done_o(frame_done),
		.rx_word_o(rx_word)
	);

	// Frame fields
	assign op = rx_word[dpsc_pkg::CMD_MSB:dpsc_pkg::ADDR_LSB];
	assign data = rx_word[dpsc_pkg::DATA_MSB:0];
	assign wp_ok = wp_s[1];
	assign preset_fire = preset_d && !preset_s[1]; // Strobe press after sync

	// Pin synchronisers for protect and preset
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wp_s <= 2'h0;
			preset_s <= 2'h3;
			preset_d <= 1'b1;
		end else begin
			wp_s <= {wp_s[0], wp_n_i};
			preset_s <= {preset_s[0], preset_strobe_n_i};
			preset_d <= preset_s[1];
		end
	end

	// Wiper setting registers
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wiper_setting_ch1_o <= dpsc_pkg::NV_RESET;
			wiper_setting_ch2_o <= dpsc_pkg::NV_RESET;
		end else if (preset_fire) begin
			wiper_setting_ch1_o <= nv_wiper_copy_ch1_o;
			wiper_setting_ch2_o <= nv_ch2;
		end else if (frame_done && wp_ok) begin
			case (op)
				dpsc_pkg::OP_LOAD_CH1: wiper_setting_ch1_o <= data;
				dpsc_pkg::OP_LOAD_CH2: wiper_setting_ch2_o <= data;
				dpsc_pkg::OP_INC_CH1: wiper_setting_ch1_o <= wiper_setting_ch1_o + 8'h01;
				dpsc_pkg::OP_SHL_CH2: wiper_setting_ch2_o <= dpsc_dbl(wiper_setting_ch2_o);
				default: begin
				end
			endcase
		end
	end

	// Nonvolatile store
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nv_wiper_copy_ch1_o <= dpsc_pkg::NV_RESET;
			nv_ch2 <= dpsc_pkg::NV_RESET;
			spare_nv_slot_a_o <= 8'h00;
			spare_nv_slot_b_o <= 8'h00;
			slot_c <= dpsc_pkg::NV_RESET;
		end else if (frame_done) begin
			case (op)
				dpsc_pkg::OP_SAVE_CH1: nv_wiper_copy_ch1_o <= wiper_setting_ch1_o;
				dpsc_pkg::OP_STORE_A: spare_nv_slot_a_o <= data;
				dpsc_pkg::OP_STORE_B: spare_nv_slot_b_o <= data;
				default: begin
				end
			endcase
		end
	end

	// Word for next frame: readback or echo
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_word <= dpsc_pkg::WORD_ZERO;
		end else if (frame_done) begin
			if (op == dpsc_pkg::OP_READ_C) begin
				tx_word <= {8'h00, slot_c};
			end else begin
				tx_word <= rx_word;
			end
		end
	end

	// Activity state
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= DPSC_IDLE;
		end else if (frame_done) begin
			case (op)
				dpsc_pkg::OP_NOP: state <= DPSC_IDLE;
				default: state <= DPSC_BUSY;
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			serial_out_line_o <= 1'b0;
			idle_o <= 1'b1;
		end else begin
			serial_out_line_o <= miso;
			idle_o <= (state == DPSC_IDLE);
		end
	end

	// Wiper, store, readback and idle command checks
	chk_shl_sat: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_SHL_CH2 && wp_ok && !preset_fire
		&& wiper_setting_ch2_o[7] |=> wiper_setting_ch2_o == dpsc_pkg::WIPER_MAX)
		else $error("shift left did not saturate");
	chk_shl_dbl: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_SHL_CH2 && wp_ok && !preset_fire
		&& !wiper_setting_ch2_o[7] |=> wiper_setting_ch2_o == {$past(wiper_setting_ch2_o[6:0]), 1'b0})
		else $error("shift left did not double");
	chk_store_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_STORE_A |=> spare_nv_slot_a_o == $past(data))
		else $error("slot a not stored");
	chk_store_b: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_STORE_B |=> spare_nv_slot_b_o == $past(data))
		else $error("slot b not stored");
	chk_read_prep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_READ_C |=> tx_word == {8'h00, $past(slot_c)})
		else $error("readback not prepared");
	chk_nop_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_NOP |=> ##1 idle_o)
		else $error("nop did not return to idle");
	chk_wp_block: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		!wp_ok && !preset_fire |=> $stable(wiper_setting_ch1_o) && $stable(wiper_setting_ch2_o))
		else $error("wiper changed while protected");
	chk_preset_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		preset_fire |=> wiper_setting_ch1_o == $past(nv_wiper_copy_ch1_o))
		else $error("preset did not reload");
	chk_inc_ch1: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_INC_CH1 && wp_ok && !preset_fire
		|=> wiper_setting_ch1_o == $past(wiper_setting_ch1_o) + 8'h01)
		else $error("increment failed");
	chk_save_ch1: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_SAVE_CH1 |=> nv_wiper_copy_ch1_o == $past(wiper_setting_ch1_o))
		else $error("save failed");

	// Direct loads, echo and preset of channel two
	chk_load_ch1: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_LOAD_CH1 && wp_ok && !preset_fire
		|=> wiper_setting_ch1_o == $past(data))
		else $error("channel one load failed");
	chk_load_ch2: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op == dpsc_pkg::OP_LOAD_CH2 && wp_ok && !preset_fire
		|=> wiper_setting_ch2_o == $past(data))
		else $error("channel two load failed");
	chk_echo_word: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op != dpsc_pkg::OP_READ_C |=> tx_word == $past(rx_word))
		else $error("command not echoed");
	chk_preset_ch2: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		preset_fire |=> wiper_setting_ch2_o == $past(nv_ch2))
		else $error("preset did not reload channel two");

	// Any other command leaves the idle state
	chk_busy_cmd: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && op != dpsc_pkg::OP_NOP |=> ##1 !idle_o)
		else $error("command did not leave idle");

	// Commands that do not move a wiper leave both alone
	chk_other_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		frame_done && !preset_fire
		&& op != dpsc_pkg::OP_LOAD_CH1 && op != dpsc_pkg::OP_LOAD_CH2
		&& op != dpsc_pkg::OP_INC_CH1 && op != dpsc_pkg::OP_SHL_CH2
		|=> $stable(wiper_setting_ch1_o) && $stable(wiper_setting_ch2_o))
		else $error("wiper moved on a non-wiper command");
endmodule
`default_nettype wire

// ### dpsc_host.sv
`default_nettype none
// Host model: 16-bit frames, MSB first
module dpsc_host (
	input wire logic clk_i,
	input wire logic miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	output logic preset_strobe_n_o,
	output logic done_o,
	output logic [15:0] rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Link idle, clock still
	initial begin
		{sclk_o, cs_n_o, mosi_o, preset_strobe_n_o, done_o, rx_o} = {4'h5, 1'b0, 16'h0000};
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// One frame; reply bit taken before each rise
	task automatic frame(input logic [15:0] w);
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = w[i];
			wt(6);
			rx_o[i] = miso_i;
			sclk_o = 1'b1;
			wt(6);
			sclk_o = 1'b0;
		end
		wt(4);
		// Released line never shows the stale bit
		mosi_o = ~mosi_o;
		cs_n_o = 1'b1;
		wt(10);
		done_o = 1'b1;
		wt(1);
		done_o = 1'b0;
	endtask
	// Preset strobe, low pulse; reload follows the press
	task automatic preset();
		preset_strobe_n_o = 1'b0;
		wt(8);
		preset_strobe_n_o = 1'b1;
		wt(8);
	endtask
endmodule
`default_nettype wire

// ### tb_dual_pot_serial_commands.sv
`default_nettype none
// Host model drives frames, a watcher compares each frame's note
module tb_dual_pot_serial_commands;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic ck;
		logic [15:0] rp;
		logic [7:0] w1, w2, nv, sa, sb;
		logic idl;
	} dpsc_note_s;
	logic clk, resetn, wp_n, sclk, cs_n, mosi, preset_n, done, miso, idl, skip;
	logic [7:0] w1, w2, nv, sa, sb, m1, m2, mn, ma, mb;
	logic [15:0] rx, last;
	dpsc_note_s q[$];
	dpsc_note_s e;
	int n_fail, checks_done, cyc;
	logic [7:0] ops [8] = '{8'hB0, 8'hB1, 8'hE0, 8'hC1, 8'h32, 8'h33, 8'h20, 8'h00};
	dpsc_host i_host (.clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
		.mosi_o(mosi), .preset_strobe_n_o(preset_n), .done_o(done), .rx_o(rx));
	dpsc_core i_dut (.core_clk_i(clk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n),
		.serial_in_line_i(mosi), .wp_n_i(wp_n), .preset_strobe_n_i(preset_n),
		.serial_out_line_o(miso), .wiper_setting_ch1_o(w1), .wiper_setting_ch2_o(w2),
		.nv_wiper_copy_ch1_o(nv), .spare_nv_slot_a_o(sa), .spare_nv_slot_b_o(sb),
		.idle_o(idl));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		checks_done++;
		if (got !== ex) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Model the command, note expectations, then send the frame
	task automatic cmd(input logic [15:0] w);
		dpsc_note_s n;
		n.ck = !skip;
		n.rp = (last[15:8] == 8'h94) ? {8'h00, dpsc_pkg::NV_RESET} : last;
		case (w[15:8])
			8'hB0: if (wp_n) m1 = w[7:0];
			8'hB1: if (wp_n) m2 = w[7:0];
			8'hE0: if (wp_n) m1 = m1 + 8'h01;
			8'hC1: if (wp_n) m2 = m2[7] ? 8'hFF : {m2[6:0], 1'b0};
			8'h20: mn = m1;
			8'h32: ma = w[7:0];
			8'h33: mb = w[7:0];
			default: ;
		endcase
		n.w1 = m1;
		n.w2 = m2;
		n.nv = mn;
		n.sa = ma;
		n.sb = mb;
		n.idl = (w[15:8] == 8'h00);
		q.push_back(n);
		last = w;
		skip = 1'b0;
		i_host.frame(w);
	endtask
	// Watcher: oldest note against the outputs after each frame
	always @(posedge done) begin
		e = q.pop_front();
		if (e.ck) chk("reply", e.rp, rx);
		chk("wiper1", {8'h00, e.w1}, {8'h00, w1});
		chk("wiper2", {8'h00, e.w2}, {8'h00, w2});
		chk("nvcopy", {8'h00, e.nv}, {8'h00, nv});
		chk("slota", {8'h00, e.sa}, {8'h00, sa});
		chk("slotb", {8'h00, e.sb}, {8'h00, sb});
		chk("idle", {15'h0000, e.idl}, {15'h0000, idl});
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		{resetn, wp_n, skip, last} = {3'b011, 16'h0000};
		{m1, m2, mn, ma, mb} = {8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
		{n_fail, checks_done, cyc} = 0;
		void'($urandom(32'h1837677B));
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		cmd(16'h0000);
		cmd(16'hB140);
		cmd(16'hB080);
		cmd(16'hE000);
		cmd(16'h2000);
		cmd(16'hB0FF);
		cmd(16'hE000);
		cmd(16'hB160);
		cmd(16'hC100);
		cmd(16'hC100);
		cmd(16'h3280);
		cmd(16'h3340);
		cmd(16'h9400);
		cmd(16'h0000);
		wp_n = 1'b0;
		foreach (ops[i]) cmd({ops[i], 8'h11});
		wp_n = 1'b1;
		i_host.preset();
		m1 = mn;
		m2 = dpsc_pkg::NV_RESET;
		skip = 1'b1;
		cmd(16'h0000);
		for (int i = 0; i < 10; i++) begin
			wp_n = 1'($urandom_range(1));
			cmd({ops[$urandom_range(7)], 8'($urandom)});
		end
		test_done();
	end
endmodule
`default_nettype wire
